// >>> hw/ccr_pkg.sv
// constants shared by the charge counter and its serial register port
package ccr_pkg;
    // register subaddresses
    localparam logic [7:0] SUB_CTRL      = 8'h01;
    localparam logic [7:0] SUB_THRESH    = 8'h02;
    localparam logic [7:0] SUB_CHARGE    = 8'h03;
    localparam logic [7:0] SUB_FAULT     = 8'h04;
    localparam logic [7:0] SUB_INT       = 8'h05;
    // reset values
    localparam logic [7:0] RST_CTRL      = 8'h00;
    localparam logic [7:0] RST_THRESH    = 8'hff;
    localparam logic [7:0] RST_CHARGE    = 8'h00;
    localparam logic [7:0] RST_FAULT     = 8'h00;
    localparam logic [7:0] RST_INT       = 8'h00;
    // field positions
    localparam int         CTRL_PRESC_LSB = 0;
    localparam int         CTRL_VSEL_LSB  = 4;
    localparam int         CTRL_VSEL_EN   = 7;
    localparam int         INT_CLEAR      = 0;
    localparam int         INT_TEST       = 1;
    localparam int         FLT_TIMEOUT    = 0;
    localparam int         FLT_OVERFLOW   = 1;
    localparam int         FLT_ALARM      = 2;
    // serial slave address
    localparam logic [6:0] SLAVE_ADDR    = 7'h64;
    // counter chain geometry
    localparam int         ACC_W         = 8;
    localparam int         RIP_W         = 42;
    localparam int         CHAIN_W       = 50;
    // timing
    localparam real        CLK_MHZ             = 10.0;
    localparam real        FULL_SCALE_ON_TIME_US = 11.74;
    localparam int         FS_CYCLES     = int'($floor(FULL_SCALE_ON_TIME_US * CLK_MHZ));
    localparam real        IRQ_RELEASE_US = 1.0;
    localparam int         REL_CYCLES    = int'($ceil(IRQ_RELEASE_US * CLK_MHZ));
    // converter burst states
    typedef enum logic [1:0] {CV_SLEEP, CV_CHARGE, CV_DISCHARGE} ccr_conv_t;
endpackage : ccr_pkg

// >>> hw/ccr_regs_if.sv
// register access strobes between the serial port and the register bank
`timescale 1ns/1ps
interface ccr_regs_if;
    logic       wr_stb;
    logic [7:0] sub_addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    modport port (output wr_stb, output sub_addr, output wdata, input rdata);
    modport regs (input wr_stb, input sub_addr, input wdata, output rdata);
endinterface : ccr_regs_if

// >>> hw/ccr_i2c_slave.sv
// serial slave: address match, subaddress pointer, byte writes and reads
`timescale 1ns/1ps
module ccr_i2c_slave (
    input  wire logic  clk,
    input  wire logic  rst,
    input  wire logic  scl_in,
    input  wire logic  sda_in,
    output logic       sda_out,
    output logic       sda_oe_n,
    ccr_regs_if.port   rb
);
    typedef enum logic [3:0] {
        ST_IDLE, ST_ADDR, ST_ACK_A, ST_SUB, ST_ACK_S, ST_WR, ST_ACK_W, ST_RD, ST_ACK_R
    } ccr_i2c_t;

    ccr_i2c_t   state_ff;
    logic       scl_q_ff;
    logic       sda_q_ff;
    logic [3:0] cnt_ff;
    logic [7:0] sh_ff;
    logic [7:0] ptr_ff;
    logic       rw_ff;
    logic       nack_ff;
    logic       oe_n_ff;
    logic       wr_ff;

    // ------------------------------------------------------------
    // bus event decode
    // ------------------------------------------------------------
    wire scl_rise = scl_in & ~scl_q_ff;
    wire scl_fall = ~scl_in & scl_q_ff;
    wire start_ev = scl_in & scl_q_ff & sda_q_ff & ~sda_in;
    wire stop_ev  = scl_in & scl_q_ff & ~sda_q_ff & sda_in;
    wire byte_in  = (state_ff == ST_ADDR) || (state_ff == ST_SUB) || (state_ff == ST_WR);
    wire addr_hit = (sh_ff[7:1] == ccr_pkg::SLAVE_ADDR);

    assign sda_out     = 1'b0;     // open drain, only ever pulls low
    assign sda_oe_n    = oe_n_ff;
    assign rb.wr_stb   = wr_ff;
    assign rb.sub_addr = ptr_ff;
    assign rb.wdata    = sh_ff;

    // ------------------------------------------------------------
    // edge history: previous clock and data line levels
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            scl_q_ff <= 1'b1;
            sda_q_ff <= 1'b1;
        end else begin
            scl_q_ff <= scl_in;
            sda_q_ff <= sda_in;
        end
    end

    // protocol sequencer, samples on clock rise and drives on clock fall
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_ff <= ST_IDLE;
            cnt_ff   <= 4'h0;
            sh_ff    <= 8'h00;
            ptr_ff   <= 8'h00;
            rw_ff    <= 1'b0;
            nack_ff  <= 1'b0;
            oe_n_ff  <= 1'b1;
            wr_ff    <= 1'b0;
        end else begin
            wr_ff <= 1'b0;
            if (start_ev) begin
                state_ff <= ST_ADDR;
                cnt_ff   <= 4'h0;
                oe_n_ff  <= 1'b1;
            end else if (stop_ev) begin
                state_ff <= ST_IDLE;
                oe_n_ff  <= 1'b1;
            end else if (scl_rise) begin
                if (byte_in) begin
                    sh_ff  <= {sh_ff[6:0], sda_in};
                    cnt_ff <= cnt_ff + 4'h1;
                end else if (state_ff == ST_RD) begin
                    cnt_ff <= cnt_ff + 4'h1;
                end else if (state_ff == ST_ACK_R) begin
                    nack_ff <= sda_in;
                end
            end else if (scl_fall) begin
                case (state_ff)
                    ST_ADDR: begin
                        if (cnt_ff == 4'h8) begin
                            state_ff <= addr_hit ? ST_ACK_A : ST_IDLE;
                            oe_n_ff  <= ~addr_hit;
                            rw_ff    <= sh_ff[0];
                        end
                    end
                    ST_SUB, ST_WR: begin
                        if (cnt_ff == 4'h8) begin
                            state_ff <= (state_ff == ST_SUB) ? ST_ACK_S : ST_ACK_W;
                            oe_n_ff  <= 1'b0;
                            if (state_ff == ST_SUB) begin
                                ptr_ff <= sh_ff;
                            end else begin
                                wr_ff <= 1'b1;
                            end
                        end
                    end
                    ST_ACK_A, ST_ACK_R: begin
                        cnt_ff <= 4'h0;
                        if (state_ff == ST_ACK_R && nack_ff) begin
                            state_ff <= ST_IDLE;
                            oe_n_ff  <= 1'b1;
                        end else if (rw_ff) begin
                            state_ff <= ST_RD;
                            sh_ff    <= rb.rdata;
                            oe_n_ff  <= rb.rdata[7];
                        end else begin
                            state_ff <= ST_SUB;
                            oe_n_ff  <= 1'b1;
                        end
                    end
                    ST_ACK_S, ST_ACK_W: begin
                        state_ff <= ST_WR;
                        cnt_ff   <= 4'h0;
                        oe_n_ff  <= 1'b1;
                        if (state_ff == ST_ACK_W) begin
                            ptr_ff <= ptr_ff + 8'h01;
                        end
                    end
                    ST_RD: begin
                        if (cnt_ff == 4'h8) begin
                            state_ff <= ST_ACK_R;
                            oe_n_ff  <= 1'b1;
                            ptr_ff   <= ptr_ff + 8'h01;
                        end else begin
                            oe_n_ff  <= sh_ff[3'(7 - cnt_ff)];
                        end
                    end
                    default: begin
                        oe_n_ff <= 1'b1;
                    end
                endcase
            end
        end
    end
endmodule : ccr_i2c_slave

// >>> hw/ccr_top.sv
// charge counter chain with its serially reached register bank
`timescale 1ns/1ps
module ccr_top (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe_n,
    input  wire logic       peak_reached,
    input  wire logic       zero_reached,
    input  wire logic       above_sleep,
    output logic            switch_charge,
    output logic            switch_discharge,
    output logic            irq_n,
    output logic [2:0]      vout_sel,
    output logic            vout_sel_valid
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    ccr_pkg::ccr_conv_t         conv_ff;
    logic [7:0]                 ctrl_ff;
    logic [7:0]                 thresh_ff;
    logic [1:0]                 int_ff;
    logic [2:0]                 fault_ff;
    logic [ccr_pkg::ACC_W-1:0]  acc_ff;
    logic [ccr_pkg::RIP_W-1:0]  rip_ff;
    logic [7:0]                 phase_cnt_ff;
    logic [7:0]                 charge_ff;
    logic                       pend_ff;
    logic                       chk_ff;
    logic                       tog_ff;
    logic [3:0]                 rel_ff;
    logic                       irq_n_ff;
    logic [2:0]                 vsel_ff;
    logic                       vsel_ok_ff;
    logic                       sw_c_ff;
    logic                       sw_d_ff;

    ccr_regs_if rb ();

    ccr_i2c_slave u_i2c (
        .clk      (clk),
        .rst      (rst),
        .scl_in   (scl_in),
        .sda_in   (sda_in),
        .sda_out  (sda_out),
        .sda_oe_n (sda_oe_n),
        .rb       (rb.port)
    );

    // ------------------------------------------------------------
    // register decode
    // ------------------------------------------------------------
    wire wr_ctrl   = rb.wr_stb && (rb.sub_addr == ccr_pkg::SUB_CTRL);
    wire wr_thresh = rb.wr_stb && (rb.sub_addr == ccr_pkg::SUB_THRESH);
    wire wr_charge = rb.wr_stb && (rb.sub_addr == ccr_pkg::SUB_CHARGE);
    wire wr_int    = rb.wr_stb && (rb.sub_addr == ccr_pkg::SUB_INT);
    wire clr_req   = wr_int && rb.wdata[ccr_pkg::INT_CLEAR];

    // readable window of the chain, moved down by the prescaler
    wire [3:0]                   presc   = ctrl_ff[ccr_pkg::CTRL_PRESC_LSB +: 4];
    wire [5:0]                   win_sh  = 6'(ccr_pkg::RIP_W) - {2'b00, presc};
    wire [ccr_pkg::CHAIN_W-1:0]  chain   = {rip_ff, acc_ff};
    wire [7:0]                   win     = 8'(chain >> win_sh);
    wire [ccr_pkg::CHAIN_W-1:0]  win_msk = ccr_pkg::CHAIN_W'(8'hff) << win_sh;
    wire [ccr_pkg::CHAIN_W-1:0]  win_new = (chain & ~win_msk)
                                         | (ccr_pkg::CHAIN_W'(rb.wdata) << win_sh);

    // read multiplexer: write-only registers read as zero
    assign rb.rdata = (rb.sub_addr == ccr_pkg::SUB_CHARGE) ? win :
                      (rb.sub_addr == ccr_pkg::SUB_FAULT)  ? {5'h00, fault_ff} :
                      8'h00;

    // ------------------------------------------------------------
    // converter burst sequence
    // ------------------------------------------------------------
    wire phase_start = (conv_ff != ccr_pkg::CV_CHARGE) && !above_sleep
                     && ((conv_ff == ccr_pkg::CV_SLEEP) || zero_reached);
    wire timeout     = (conv_ff == ccr_pkg::CV_CHARGE)
                     && (phase_cnt_ff == 8'(ccr_pkg::FS_CYCLES)) && !peak_reached;
    wire phase_end   = (conv_ff == ccr_pkg::CV_CHARGE) && peak_reached;
    wire [15:0] scaled = 16'(phase_cnt_ff) * 16'h00ff / 16'(ccr_pkg::FS_CYCLES);
    wire [7:0]  charge_q = (phase_cnt_ff >= 8'(ccr_pkg::FS_CYCLES)) ? 8'hff : scaled[7:0];

    // next converter state: sleep only after a discharge ends
    ccr_pkg::ccr_conv_t nxt_conv;
    always_comb begin
        nxt_conv = conv_ff;
        case (conv_ff)
            ccr_pkg::CV_SLEEP: begin
                if (!above_sleep) nxt_conv = ccr_pkg::CV_CHARGE;
            end
            ccr_pkg::CV_CHARGE: begin
                if (peak_reached) nxt_conv = ccr_pkg::CV_DISCHARGE;
            end
            ccr_pkg::CV_DISCHARGE: begin
                if (zero_reached) begin
                    nxt_conv = above_sleep ? ccr_pkg::CV_SLEEP : ccr_pkg::CV_CHARGE;
                end
            end
            default: nxt_conv = ccr_pkg::CV_SLEEP;
        endcase
    end

    // switch drive and charge phase timer
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            conv_ff      <= ccr_pkg::CV_SLEEP;
            sw_c_ff      <= 1'b0;
            sw_d_ff      <= 1'b0;
            phase_cnt_ff <= 8'h00;
            charge_ff    <= 8'h00;
        end else begin
            conv_ff <= nxt_conv;
            sw_c_ff <= (nxt_conv == ccr_pkg::CV_CHARGE);
            sw_d_ff <= (nxt_conv == ccr_pkg::CV_DISCHARGE);
            if (phase_start) begin
                phase_cnt_ff <= 8'h00;
            end else if (conv_ff == ccr_pkg::CV_CHARGE && !timeout) begin
                phase_cnt_ff <= phase_cnt_ff + 8'h01;
            end
            if (phase_end) begin
                charge_ff <= charge_q;
            end
        end
    end

    // ------------------------------------------------------------
    // accumulator and ripple counter
    // ------------------------------------------------------------
    wire [8:0]  acc_sum = {1'b0, acc_ff} + {1'b0, charge_ff};
    wire        carry   = phase_start && acc_sum[8];
    wire [42:0] rip_msk = (43'h1 << (6'(ccr_pkg::RIP_W) - {2'b00, presc})) - 43'h1;
    wire        ovf_ev  = carry && ((rip_ff & rip_msk[41:0]) == rip_msk[41:0]);

    // chain updates only on a charge start or a window write; sleep holds it
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            acc_ff <= '0;
            rip_ff <= '0;
        end else if (wr_charge) begin
            {rip_ff, acc_ff} <= win_new;
        end else if (phase_start) begin
            acc_ff <= acc_sum[7:0];
            rip_ff <= rip_ff + ccr_pkg::RIP_W'(carry);
        end
    end

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_ff    <= ccr_pkg::RST_CTRL;
            thresh_ff  <= ccr_pkg::RST_THRESH;
            int_ff     <= ccr_pkg::RST_INT[1:0];
            vsel_ff    <= 3'h0;
            vsel_ok_ff <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                ctrl_ff <= rb.wdata;
            end
            if (wr_ctrl && rb.wdata[ccr_pkg::CTRL_VSEL_EN]) begin
                vsel_ff    <= rb.wdata[ccr_pkg::CTRL_VSEL_LSB +: 3];
                vsel_ok_ff <= 1'b1;
            end
            if (wr_thresh) begin
                thresh_ff <= rb.wdata;
            end
            // clear bit self-clears one cycle after acting; test bit holds
            int_ff[ccr_pkg::INT_CLEAR] <= clr_req;
            if (wr_int) begin
                int_ff[ccr_pkg::INT_TEST] <= rb.wdata[ccr_pkg::INT_TEST];
            end
        end
    end

    // ------------------------------------------------------------
    // faults, threshold check and interrupt pin
    // ------------------------------------------------------------
    wire alarm_ev = chk_ff && (win >= thresh_ff);
    wire any_ev   = timeout || ovf_ev || alarm_ev;
    wire [2:0] ev_vec = {alarm_ev, ovf_ev, timeout};

    // sticky faults: a new event wins over a clear in the same cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fault_ff <= ccr_pkg::RST_FAULT[2:0];
            pend_ff  <= 1'b0;
            chk_ff   <= 1'b0;
        end else begin
            chk_ff   <= phase_end || wr_charge;
            fault_ff <= (clr_req ? 3'h0 : fault_ff) | ev_vec;
            pend_ff  <= (pend_ff && !clr_req) || any_ev;
        end
    end

    // pin driver: release window after a clear, test mode shows ripple clock
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rel_ff   <= 4'h0;
            tog_ff   <= 1'b0;
            irq_n_ff <= 1'b1;
        end else begin
            if (clr_req) begin
                rel_ff <= 4'(ccr_pkg::REL_CYCLES);
            end else if (rel_ff != 4'h0) begin
                rel_ff <= rel_ff - 4'h1;
            end
            tog_ff <= tog_ff ^ carry;
            if (int_ff[ccr_pkg::INT_TEST]) begin
                irq_n_ff <= ~tog_ff;
            end else begin
                irq_n_ff <= ~(pend_ff && (rel_ff == 4'h0) && !clr_req);
            end
        end
    end

    assign irq_n            = irq_n_ff;
    assign switch_charge    = sw_c_ff;
    assign switch_discharge = sw_d_ff;
    assign vout_sel         = vsel_ff;
    assign vout_sel_valid   = vsel_ok_ff;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    AST_SLEEP_HOLD: assert property (
        (conv_ff == ccr_pkg::CV_SLEEP) && above_sleep && !wr_charge |=> $stable(chain))
        else $error("chain moved while asleep");
    AST_BURST: assert property (
        (conv_ff == ccr_pkg::CV_CHARGE) && peak_reached |=> switch_discharge && !switch_charge)
        else $error("discharge did not follow peak");
    AST_TIMEOUT: assert property (
        timeout |=> fault_ff[ccr_pkg::FLT_TIMEOUT])
        else $error("timeout flag not set");
    AST_CARRY: assert property (
        carry && !wr_charge |=> rip_ff == $past(rip_ff) + ccr_pkg::RIP_W'(1))
        else $error("ripple did not advance on carry");
    AST_ADD: assert property (
        phase_start && !wr_charge |=> acc_ff == $past(acc_sum[7:0]))
        else $error("charge not accumulated");
    AST_ALARM: assert property (
        chk_ff && (win >= thresh_ff) |=> fault_ff[ccr_pkg::FLT_ALARM] ##1 !irq_n || rel_ff != 4'h0
            || int_ff[ccr_pkg::INT_TEST] || clr_req)
        else $error("alarm not flagged");
    AST_CLR_SELF: assert property (
        int_ff[ccr_pkg::INT_CLEAR] && !clr_req |=> !int_ff[ccr_pkg::INT_CLEAR])
        else $error("clear bit stuck");
    AST_IRQ_IDLE: assert property (
        !pend_ff && !int_ff[ccr_pkg::INT_TEST] |=> irq_n)
        else $error("interrupt low with nothing pending");
    AST_RO_ZERO: assert property (
        rb.sub_addr == ccr_pkg::SUB_FAULT |-> rb.rdata[7:3] == 5'h00)
        else $error("unused fault bits not zero");
    AST_SDA_LOW: assert property (
        $fell(sda_oe_n) |-> !$past(scl_in))
        else $error("data line pulled while clock line high");
    AST_CHG_SAT: assert property (
        phase_end && (phase_cnt_ff >= 8'(ccr_pkg::FS_CYCLES)) |=> charge_ff == 8'hff)
        else $error("overlong charge phase not saturated");
    AST_WIN_WR: assert property (
        wr_charge |=> win == $past(rb.wdata))
        else $error("charge register write lost");
    AST_CHK_ONLY: assert property (
        !chk_ff && !fault_ff[ccr_pkg::FLT_ALARM] |=> !fault_ff[ccr_pkg::FLT_ALARM])
        else $error("alarm flag set without a check");
    AST_REL: assert property (
        clr_req && !int_ff[ccr_pkg::INT_TEST] |=> irq_n)
        else $error("interrupt pin not released by a clear");
    AST_TEST_PIN: assert property (
        int_ff[ccr_pkg::INT_TEST] && carry ##1 int_ff[ccr_pkg::INT_TEST]
            |=> irq_n != $past(irq_n))
        else $error("ripple clock not seen on interrupt pin");
endmodule : ccr_top

// >>> testbench/ccr_host_model.sv
// serial bus master model: drives the clock line and pulls the data line low
`timescale 1ns/1ps
module ccr_host_model (
    input  wire logic clk,
    input  wire logic sda_line,
    output logic      scl,
    output logic      sda_low
);
    // both lines released while idle
    initial begin
        scl     = 1'b1;
        sda_low = 1'b0;
    end
    // hold each level four clocks, twice the minimum the slave needs
    task automatic half(input logic c, input logic d);
        repeat (4) @(posedge clk);
        scl     <= c;
        sda_low <= d;
    endtask : half
    // start or repeated start: data falls while the clock is high
    task automatic start();
        half(1'b0, sda_low);
        half(1'b0, 1'b0);
        half(1'b1, 1'b0);
        half(1'b1, 1'b1);
    endtask : start
    // stop: data rises while the clock is high
    task automatic stop();
        half(1'b0, sda_low);
        half(1'b0, 1'b1);
        half(1'b1, 1'b1);
        half(1'b1, 1'b0);
    endtask : stop
    // one bit, sampled two clocks after the clock line rises
    task automatic bit_x(input logic d, output logic q);
        half(1'b0, sda_low);
        half(1'b0, !d);
        half(1'b1, !d);
        repeat (2) @(posedge clk);
        q = sda_line;
    endtask : bit_x
    // byte msb first, ninth bit released (ack in, or nack out on reads)
    task automatic xfer(input logic [7:0] d, output logic [7:0] q, output logic ack);
        logic b;
        for (int i = 7; i >= 0; i--) begin
            bit_x(d[i], b);
            q[i] = b;
        end
        bit_x(1'b1, b);
        ack = !b;
    endtask : xfer
endmodule : ccr_host_model

// >>> testbench/ccr_top_tb.sv
// self-checking bench for the charge counter and its register port
`timescale 1ns/1ps
module ccr_top_tb;
    logic       clk, rst, peak_reached, zero_reached, above_sleep;
    logic       scl, sda_low, sda_out, sda_oe_n, sw_c, sw_d, irq_n, vsel_ok, ack;
    logic [2:0] vout_sel;
    logic [7:0] r;
    int         err_count, check_count, thr, chg;
    // behavioural model of the counter chain and the prescaler
    logic [ccr_pkg::CHAIN_W-1:0] m_chain;
    int                          m_presc;
    wire        sda_line = !sda_low && (sda_oe_n || sda_out);
    ccr_host_model i_host (.clk(clk), .sda_line(sda_line), .scl(scl), .sda_low(sda_low));
    ccr_top i_dut (.clk(clk), .rst(rst), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
        .sda_oe_n(sda_oe_n), .peak_reached(peak_reached), .zero_reached(zero_reached),
        .above_sleep(above_sleep), .switch_charge(sw_c), .switch_discharge(sw_d),
        .irq_n(irq_n), .vout_sel(vout_sel), .vout_sel_valid(vsel_ok));
    // 10 MHz clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // compare and count
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_sim
    // bounded wait for a switch state
    task automatic wait_sw(input logic c, input logic d);
        int n;
        for (n = 0; n < 50 && !(sw_c === c && sw_d === d); n++) @(posedge clk);
        if (n == 50) begin
            err_count++;
            $display("wrong value at %0t: switch wait expired", $time);
            end_sim();
        end
    endtask : wait_sw
    // readable window of the model chain
    function automatic logic [7:0] m_win();
        return 8'(m_chain >> (ccr_pkg::RIP_W - m_presc));
    endfunction : m_win
    task automatic wr(input logic [7:0] sub, input logic [7:0] val);
        if (sub == ccr_pkg::SUB_CTRL) m_presc = int'(val[3:0]);
        if (sub == ccr_pkg::SUB_CHARGE) m_chain[ccr_pkg::RIP_W - m_presc +: 8] = val;
        i_host.start();
        i_host.xfer(8'hc8, r, ack);
        chk({7'h0, ack}, 8'h01);
        i_host.xfer(sub, r, ack);
        i_host.xfer(val, r, ack);
        i_host.stop();
    endtask : wr
    task automatic rd(input logic [7:0] sub, input logic [7:0] exp);
        i_host.start();
        i_host.xfer(8'hc8, r, ack);
        i_host.xfer(sub, r, ack);
        i_host.start();
        i_host.xfer(8'hc9, r, ack);
        i_host.xfer(8'hff, r, ack);
        i_host.stop();
        chk(r, exp);
    endtask : rd
    // one charge phase of len cycles, then discharge into sleep or a new charge
    task automatic burst(input int len, input logic last);
        above_sleep <= 1'b0;
        wait_sw(1'b1, 1'b0);
        repeat (len) @(posedge clk);
        peak_reached <= 1'b1;
        wait_sw(1'b0, 1'b1);
        peak_reached <= 1'b0;
        above_sleep  <= last;
        zero_reached <= 1'b1;
        wait_sw(!last, 1'b0);
        zero_reached <= 1'b0;
    endtask : burst
    //----------------------------------------
    // main sequence
    //----------------------------------------
    initial begin
        rst          = 1'b1;
        peak_reached = 1'b0;
        zero_reached = 1'b0;
        above_sleep  = 1'b1;
        err_count    = 0;
        check_count  = 0;
        m_chain      = '0;
        m_presc      = 0;
        thr          = $urandom(32'h4181f10c);
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        rd(ccr_pkg::SUB_CHARGE, 8'h00);
        rd(ccr_pkg::SUB_FAULT, 8'h00);
        rd(ccr_pkg::SUB_THRESH, 8'h00);
        chk({7'h0, irq_n}, 8'h01);
        i_host.start();
        i_host.xfer(8'hca, r, ack);
        i_host.stop();
        chk({7'h0, ack}, 8'h00);
        $display("test reset and address done");
        // charge phase outlives full scale, then discharge into sleep
        above_sleep <= 1'b0;
        wait_sw(1'b1, 1'b0);
        repeat (130) @(posedge clk);
        peak_reached <= 1'b1;
        wait_sw(1'b0, 1'b1);
        peak_reached <= 1'b0;
        above_sleep  <= 1'b1;
        zero_reached <= 1'b1;
        wait_sw(1'b0, 1'b0);
        zero_reached <= 1'b0;
        rd(ccr_pkg::SUB_FAULT, 8'h01);
        chk({7'h0, irq_n}, 8'h00);
        wr(ccr_pkg::SUB_INT, 8'h01);
        repeat (20) @(posedge clk);
        chk({7'h0, irq_n}, 8'h01);
        rd(ccr_pkg::SUB_FAULT, 8'h00);
        wr(ccr_pkg::SUB_THRESH, 8'h00);
        rd(ccr_pkg::SUB_FAULT, 8'h00);
        $display("test timeout done");
        // random threshold against charge, first pass on the equal boundary
        for (int i = 0; i < 4; i++) begin
            chg = $urandom_range(255);
            thr = (i == 0) ? chg : $urandom_range(255);
            wr(ccr_pkg::SUB_THRESH, thr[7:0]);
            wr(ccr_pkg::SUB_CHARGE, chg[7:0]);
            wr(ccr_pkg::SUB_FAULT, 8'hff);
            rd(ccr_pkg::SUB_CHARGE, m_win());
            rd(ccr_pkg::SUB_FAULT, (chg >= thr) ? 8'h04 : 8'h00);
            chk({7'h0, irq_n}, {7'h0, chg < thr});
            wr(ccr_pkg::SUB_INT, 8'h01);
            repeat (20) @(posedge clk);
        end
        $display("test alarm done");
        // prescaler moves the readable window down the chain
        wr(ccr_pkg::SUB_CTRL, 8'h04);
        rd(ccr_pkg::SUB_CHARGE, m_win());
        wr(ccr_pkg::SUB_CHARGE, chg[7:0] ^ 8'h5a);
        rd(ccr_pkg::SUB_CHARGE, m_win());
        wr(ccr_pkg::SUB_CTRL, 8'h00);
        rd(ccr_pkg::SUB_CHARGE, m_win());
        $display("test prescaler done");
        // counter check: a full-scale charge then one more add carries once
        wr(ccr_pkg::SUB_INT, 8'h02);
        chk({7'h0, irq_n}, 8'h01);
        burst(40, 1'b0);
        burst(0, 1'b1);
        chk({7'h0, irq_n}, 8'h00);
        $display("test counter check done");
        wr(ccr_pkg::SUB_CTRL, 8'hd0);
        chk({4'h0, vsel_ok, vout_sel}, 8'h0d);
        wr(ccr_pkg::SUB_CTRL, 8'h30);
        chk({4'h0, vsel_ok, vout_sel}, 8'h0d);
        $display("test voltage select done");
        end_sim();
    end
endmodule : ccr_top_tb
